// >>> design/lcsr_fifo.sv
// Synchronous FIFO for self-ID quadlets on their way to host memory.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module lcsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic [AW:0] used;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;

  // Occupancy from pointers with a wrap bit
  assign used = wrPtr_q - rdPtr_q;
  assign inReady = (used != DEPTH[AW:0]);
  assign outValid = (used != '0);
  assign outData = mem[rdPtr_q[AW-1:0]];

  // Pointers; flush drops everything held
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr_q[AW-1:0]] <= inData;
  end
endmodule

// >>> design/lcsr_link_regs.sv
// Link control and self-ID registers of a serial-bus link controller.
// Assumes a host register port answered one cycle later, a PHY clock arriving
// as a pin, and a host memory write port with ready back-pressure.
`timescale 1ns/10ps
// Summary of operation
// - Control register sits at a set address and a clear address.
// - Tuning permission bit 23 is loaded from the configuration memory.
// - Tuning permission resets only on platform reset, not software reset.
// - Control bits 21 and 20 always read zero.
// - Link power status bit 19 gates all link-to-PHY communication.
// - Access to PHY-clock registers while that clock stops is aborted.
// - With the suppress option set such accesses return all ones.
// - Offsets DCh-F0h and 100h-11Ch belong to the PHY-clock domain.
// - Bit 18 enables buffered writes; changed only while detached.
// - Attach enable clears on any reset; software sets it when ready.
// - Without attach enable no packet is received, processed or sent.
// - Software reset clears link state, FIFOs and link registers.
// - Software reset bit reads one until the reset sequence ends.
// - Buffer base holds bits 31-11; bits 10-0 read zero.
// - Fault bit 31 tracks errors of the latest self-ID reception.
// - Epoch field 23-16 counts bus resets and wraps after 255.
// - Quadlet field 10-2 counts quadlets written to host memory.
// - Quadlet field zeroes when a new self-ID reception begins.
// - Tally bits 30-24, 15-11 and 1-0 always read zero.
module lcsr_link_regs import lcsr_pkg::*; #(
  parameter int FIFO_DEPTH = 16,
  parameter int IDLE_CYC = PHY_IDLE_CYC
) (
  // Clock and platform reset
  input wire logic clk,
  input wire logic rst_n,
  // Host register port
  input wire logic regReq,
  input wire lcsr_req_type regCmd,
  output logic regAck,
  output logic regAbort,
  output logic [31:0] regRdata,
  // Configuration inputs
  input wire logic suppress_abort_return_ones,
  input wire logic permitLoadValid,
  input wire logic permitLoadValue,
  // PHY link pins
  input wire logic phyClkPin,
  input wire lcsr_link_type linkPins,
  input wire logic [31:0] phyDataPins,
  // Host memory write port for self-ID quadlets
  output logic memWrValid,
  output logic [31:0] memWrAddr,
  output logic [31:0] memWrData,
  input wire logic memWrReady,
  input wire logic memWrError,
  // Control levels to the link
  output logic link_power_status,
  output logic bus_attach_enable,
  output logic buffered_write_allow,
  output logic phy_extras_on,
  output logic linkActive
);
  localparam int NPIN = $bits(lcsr_link_type);

  // Register state
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:BASE_LSB] base_q;
  logic fault_q;
  logic errAcc_q;
  logic [7:0] epoch_q;
  logic [QUAD_W-1:0] quads_q;
  lcsr_rst_type rstState_q;
  logic [$clog2(SWRST_CYC+1)-1:0] rstCnt_q;
  logic [$clog2(IDLE_CYC+1)-1:0] idleCnt_q;
  logic regAck_q;
  logic regAbort_q;
  logic [31:0] regRdata_q;

  // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree
  logic [2:0] clkSync_q;
  logic clkLvl_q;
  logic [NPIN-1:0] pinS1_q;
  logic [NPIN-1:0] pinS2_q;
  logic [NPIN-1:0] pinS3_q;
  logic [NPIN-1:0] pinLvl_q;
  logic [31:0] datS1_q;
  logic [31:0] datS2_q;
  logic [31:0] datS3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkSync_q <= 3'h0;
      clkLvl_q <= 1'b0;
    end else begin
      clkSync_q <= {clkSync_q[1:0], phyClkPin};
      if (clkSync_q[1] == clkSync_q[2]) clkLvl_q <= clkSync_q[2];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pinS1_q[gi] <= 1'b0;
          pinS2_q[gi] <= 1'b0;
          pinS3_q[gi] <= 1'b0;
          pinLvl_q[gi] <= 1'b0;
        end else begin
          pinS1_q[gi] <= linkPins[gi];
          pinS2_q[gi] <= pinS1_q[gi];
          pinS3_q[gi] <= pinS2_q[gi];
          if (pinS2_q[gi] == pinS3_q[gi]) pinLvl_q[gi] <= pinS3_q[gi];
        end
      end
    end
  endgenerate

  // Data bus is only used at a sampled PHY clock edge, when it is settled
  always_ff @(posedge clk) begin
    datS1_q <= phyDataPins;
    datS2_q <= datS1_q;
    datS3_q <= datS2_q;
  end

  // PHY clock edge and stopped-clock detection
  wire phyRise = !clkLvl_q && clkSync_q[1] && clkSync_q[2];
  wire phyStopped = (idleCnt_q == IDLE_CYC[$bits(idleCnt_q)-1:0]);

  always_ff @(posedge clk) begin
    if (!rst_n || phyRise) begin
      idleCnt_q <= '0;
    end else if (!phyStopped) begin
      idleCnt_q <= idleCnt_q + 1'b1;
    end
  end

  // Link events, taken on PHY clock rising edges only
  lcsr_link_type ev;
  wire swResetBusy = (rstState_q == RST_RUN);
  wire linkOn = ctrl_q[BIT_ATTACH] && ctrl_q[BIT_LPS] && !swResetBusy;
  assign ev = phyRise && linkOn ? lcsr_link_type'(pinLvl_q) : lcsr_link_type'('0);

  // Register decode
  wire [11:0] addr = regCmd.addr;
  wire hit = regReq && !regAck_q && !regAbort_q;
  wire isSet = (addr == OFS_CTRL_SET);
  wire isClr = (addr == OFS_CTRL_CLR);
  wire isBase = (addr == OFS_SID_BASE);
  wire isTally = (addr == OFS_SID_TALLY);
  wire inLinkA = (addr >= OFS_LINKA_LO) && (addr <= OFS_LINKA_HI);
  wire inLinkB = (addr >= OFS_LINKB_LO) && (addr <= OFS_LINKB_HI);
  wire phyDomain = inLinkA || inLinkB;
  wire stoppedAccess = hit && phyDomain && phyStopped;
  wire doAbort = stoppedAccess && !suppress_abort_return_ones;
  wire wrSet = hit && regCmd.write && isSet;
  wire wrClr = hit && regCmd.write && isClr;
  wire wrBase = hit && regCmd.write && isBase;

  // Read values: reserved bits of the control read zero
  wire [31:0] ctrlView = ctrl_q & (CTRL_RW_MASK | (32'h1 << BIT_PERMIT) | (32'h1 << BIT_SWRST));
  wire [31:0] baseView = {base_q, 11'h000};
  wire [31:0] tallyView = {fault_q, 7'h00, epoch_q, 5'h00, quads_q, 2'h0};
  logic [31:0] rdMux;
  always_comb begin
    if (isSet || isClr) begin
      rdMux = ctrlView;
    end else if (isBase) begin
      rdMux = baseView;
    end else if (isTally) begin
      rdMux = tallyView;
    end else if (phyDomain && phyStopped) begin
      rdMux = ALL_ONES;
    end else begin
      rdMux = 32'h0000_0000;
    end
  end

  // Host port answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regAck_q <= 1'b0;
      regAbort_q <= 1'b0;
      regRdata_q <= 32'h0000_0000;
    end else begin
      regAck_q <= hit && !doAbort;
      regAbort_q <= doAbort;
      if (hit && !regCmd.write) regRdata_q <= doAbort ? 32'h0000_0000 : rdMux;
    end
  end

  // Control next value: set and clear writes, software fields only
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrSet) ctrl_d = ctrl_d | (regCmd.wdata & CTRL_RW_MASK);
    if (wrClr) ctrl_d = ctrl_d & ~(regCmd.wdata & CTRL_RW_MASK);
    if (wrClr && regCmd.wdata[BIT_PERMIT]) ctrl_d[BIT_PERMIT] = 1'b0;
    if (permitLoadValid) ctrl_d[BIT_PERMIT] = permitLoadValue;
    if (wrSet && regCmd.wdata[BIT_SWRST]) ctrl_d[BIT_SWRST] = 1'b1;
    if (swResetBusy) begin
      ctrl_d = CTRL_RESET;
      ctrl_d[BIT_PERMIT] = ctrl_q[BIT_PERMIT];
      ctrl_d[BIT_SWRST] = (rstCnt_q != '0);
    end
    ctrl_d[21:20] = 2'b00;
  end

  // Platform reset restores everything, the permission bit included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Software reset sequence; holds the link in reset for a fixed time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rstState_q <= RST_IDLE;
      rstCnt_q <= '0;
    end else begin
      case (rstState_q)
        RST_IDLE: begin
          if (wrSet && regCmd.wdata[BIT_SWRST]) begin
            rstState_q <= RST_RUN;
            rstCnt_q <= SWRST_CYC[$bits(rstCnt_q)-1:0];
          end
        end
        RST_RUN: begin
          if (rstCnt_q == '0) begin
            rstState_q <= RST_IDLE;
          end else begin
            rstCnt_q <= rstCnt_q - 1'b1;
          end
        end
        default: rstState_q <= RST_IDLE;
      endcase
    end
  end

  // Buffer base: upper bits writable, cleared by either reset
  always_ff @(posedge clk) begin
    if (!rst_n || swResetBusy) begin
      base_q <= '0;
    end else if (wrBase) begin
      base_q <= regCmd.wdata[31:BASE_LSB];
    end
  end

  // Quadlet FIFO between the link and host memory
  logic fifoInReady;
  logic fifoOutValid;
  logic [31:0] fifoOutData;
  wire fifoFlush = swResetBusy || ev.reportBegin || !ctrl_q[BIT_ATTACH];
  lcsr_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(fifoFlush),
    .inValid(ev.quadValid),
    .inData(datS3_q),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(memWrReady)
  );

  // The PHY cannot be stalled, so a quadlet meeting a full FIFO is a fault
  wire overflow = ev.quadValid && !fifoInReady;
  wire memDone = fifoOutValid && memWrReady && !fifoFlush;
  assign memWrValid = fifoOutValid && !fifoFlush;
  assign memWrData = fifoOutData;
  assign memWrAddr = {base_q, 11'h000} + {21'h0, quads_q, 2'h0};

  // Self-ID tally: epoch, quadlet count and error summary
  always_ff @(posedge clk) begin
    if (!rst_n || swResetBusy) begin
      fault_q <= 1'b0;
      errAcc_q <= 1'b0;
      epoch_q <= 8'h00;
      quads_q <= '0;
    end else begin
      if (ev.busReset) epoch_q <= epoch_q + 8'h01;
      if (ev.reportBegin) begin
        quads_q <= '0;
        errAcc_q <= 1'b0;
      end else begin
        if (memDone) quads_q <= quads_q + 1'b1;
        if (ev.hwError || overflow || (memWrError && memWrValid)) errAcc_q <= 1'b1;
      end
      if (ev.reportEnd) fault_q <= errAcc_q || ev.hwError || overflow || (memWrError && memWrValid);
    end
  end

  // Outputs
  assign regAck = regAck_q;
  assign regAbort = regAbort_q;
  assign regRdata = regRdata_q;
  assign link_power_status = ctrl_q[BIT_LPS];
  assign bus_attach_enable = ctrl_q[BIT_ATTACH];
  assign buffered_write_allow = ctrl_q[BIT_BUFWR];
  assign phy_extras_on = ctrl_q[BIT_EXTRAS];
  assign linkActive = linkOn;
endmodule

// >>> design/lcsr_pkg.sv
// Package for the link control and self-ID register block.
// Assumes a 50 MHz host clock and a PHY clock sampled as a pin.
package lcsr_pkg;

  // Register offsets on the host register port
  localparam logic [11:0] OFS_CTRL_SET = 12'h050;
  localparam logic [11:0] OFS_CTRL_CLR = 12'h054;
  localparam logic [11:0] OFS_SID_BASE = 12'h064;
  localparam logic [11:0] OFS_SID_TALLY = 12'h068;
  localparam logic [11:0] OFS_LINKA_LO = 12'h0DC;
  localparam logic [11:0] OFS_LINKA_HI = 12'h0F0;
  localparam logic [11:0] OFS_LINKB_LO = 12'h100;
  localparam logic [11:0] OFS_LINKB_HI = 12'h11C;

  // Control field positions
  localparam int BIT_PERMIT = 23;
  localparam int BIT_EXTRAS = 22;
  localparam int BIT_LPS = 19;
  localparam int BIT_BUFWR = 18;
  localparam int BIT_ATTACH = 17;
  localparam int BIT_SWRST = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0080_0000;
  localparam logic [31:0] CTRL_RW_MASK = 32'h004E_0000;

  // Self-ID field positions
  localparam int BASE_LSB = 11;
  localparam int TALLY_FAULT = 31;
  localparam int EPOCH_LSB = 16;
  localparam int QUAD_LSB = 2;
  localparam int QUAD_W = 9;

  // Timing
  localparam int CLK_NS = 20;
  localparam int SWRST_NS = 320;
  localparam int SWRST_CYC = (SWRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int PHY_IDLE_NS = 640;
  localparam int PHY_IDLE_CYC = (PHY_IDLE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

  // Host register request
  typedef struct packed {
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } lcsr_req_type;

  // Link-side pin events, bit order of the sampled group
  typedef struct packed {
    logic busReset;
    logic reportBegin;
    logic reportEnd;
    logic quadValid;
    logic hwError;
  } lcsr_link_type;

  typedef enum logic [0:0] {
    RST_IDLE = 1'b0,
    RST_RUN = 1'b1
  } lcsr_rst_type;

endpackage

// >>> verif/lcsr_link_monitor.sv
// Checker for the link control and self-ID register block.
// Sees only the top-level ports; attached by the bind below.
`timescale 1ns/10ps
module lcsr_link_monitor import lcsr_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic regReq,
  input wire lcsr_req_type regCmd,
  input wire logic regAck,
  input wire logic regAbort,
  input wire logic [31:0] regRdata,
  input wire logic suppress_abort_return_ones,
  // Memory port and control levels
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic [31:0] memWrAddr,
  input wire logic [31:0] memWrData,
  input wire logic link_power_status,
  input wire logic bus_attach_enable,
  input wire logic linkActive
);
  logic lastReq_q;
  logic lastSup_q;
  lcsr_req_type lastCmd_q;
  // Request of one cycle back, which the answer belongs to
  always_ff @(posedge clk) begin
    lastReq_q <= rst_n & regReq;
    lastSup_q <= suppress_abort_return_ones;
    lastCmd_q <= regCmd;
  end
  // Decodes of the answered request
  wire logic rdDone = regAck && lastReq_q && !lastCmd_q.write;
  wire logic inA = lastCmd_q.addr >= OFS_LINKA_LO && lastCmd_q.addr <= OFS_LINKA_HI;
  wire logic inPhy = inA || (lastCmd_q.addr >= OFS_LINKB_LO && lastCmd_q.addr <= OFS_LINKB_HI);
  wire logic wrSet = regAck && lastReq_q && lastCmd_q.write && lastCmd_q.addr == OFS_CTRL_SET;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  answer_has_req_a: assert property ((regAck || regAbort) |-> lastReq_q && !(regAck && regAbort))
    else $error("answer without a request");
  ctrl_rsvd_a: assert property (rdDone && lastCmd_q.addr == OFS_CTRL_SET |-> regRdata[21:20] == 2'h0)
    else $error("control bits 21-20 not zero");
  base_low_a: assert property (rdDone && lastCmd_q.addr == OFS_SID_BASE |-> regRdata[10:0] == 11'h000)
    else $error("base low bits not zero");
  tally_rsvd_a: assert property (rdDone && lastCmd_q.addr == OFS_SID_TALLY |->
    {regRdata[30:24], regRdata[15:11], regRdata[1:0]} == 14'h0000)
    else $error("tally reserved bits not zero");
  abort_cause_a: assert property (regAbort |-> inPhy && !lastSup_q)
    else $error("abort outside stopped-clock ranges");
  ones_return_a: assert property (rdDone && inPhy && lastSup_q |-> regRdata == ALL_ONES || regRdata == 32'h0)
    else $error("suppressed access data wrong");
  attach_set_a: assert property (wrSet && lastCmd_q.wdata[BIT_ATTACH] && !lastCmd_q.wdata[BIT_SWRST]
    |-> bus_attach_enable)
    else $error("attach enable not set");
  active_gate_a: assert property (linkActive |-> link_power_status && bus_attach_enable)
    else $error("link active without power and attach");
  wr_hold_a: assert property (memWrValid && !memWrReady && linkActive |=>
    !linkActive || (memWrValid && $stable(memWrAddr) && $stable(memWrData)))
    else $error("stalled memory write changed");
  detach_idle_a: assert property (!bus_attach_enable [*3] |-> !memWrValid)
    else $error("memory write while detached");
  abort_seen_c: cover property (regAbort);
  ones_seen_c: cover property (rdDone && regRdata == ALL_ONES);
  stall_seen_c: cover property (memWrValid && !memWrReady);
endmodule
bind lcsr_link_regs lcsr_link_monitor mon (.clk, .rst_n, .regReq, .regCmd, .regAck, .regAbort, .regRdata,
  .suppress_abort_return_ones, .memWrValid, .memWrReady, .memWrAddr, .memWrData, .link_power_status,
  .bus_attach_enable, .linkActive);

// >>> verif/lcsr_link_regs_test.sv
// Self-checking bench for the link control and self-ID register block.
// Drives the register port and memory side; the PHY model drives the link pins.
`timescale 1ns/10ps
module lcsr_link_regs_test import lcsr_pkg::*;;
  logic clk, rst_n, regReq, regAck, regAbort, suppress_abort_return_ones, permitLoadValid, permitLoadValue;
  logic phyClkPin, memWrValid, memWrReady, memWrError, link_power_status, bus_attach_enable;
  logic buffered_write_allow, phy_extras_on, linkActive, rab;
  logic [31:0] regRdata, phyDataPins, memWrAddr, memWrData, base, rq;
  logic [11:0] phyAddr [5] = '{12'h0DC, 12'h0F0, 12'h100, 12'h11C, 12'h0D8};
  lcsr_req_type regCmd;
  lcsr_link_type linkPins;
  int fails, check_count, cycles, wrIdx;
  lcsr_link_regs uut (.clk, .rst_n, .regReq, .regCmd, .regAck, .regAbort, .regRdata, .suppress_abort_return_ones,
    .permitLoadValid, .permitLoadValue, .phyClkPin, .linkPins, .phyDataPins, .memWrValid, .memWrAddr,
    .memWrData, .memWrReady, .memWrError, .link_power_status, .bus_attach_enable, .buffered_write_allow,
    .phy_extras_on, .linkActive);
  lcsr_phy_model phy (.phyClkPin, .linkPins, .phyDataPins);
  // 50 MHz host clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic conclude;
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkBit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Request held until the answer pulse is seen, then dropped
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic ab);
    int n;
    @(posedge clk);
    #1;
    regReq = 1'b1;
    regCmd = '{write: w, addr: a, wdata: d};
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      #1;
      if (regAck === 1'b1 || regAbort === 1'b1) break;
    end
    if (n == 8) chkBit("answer", 1'b1, 1'b0);
    ab = regAbort;
    q = regRdata;
    regReq = 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d, rq, rab);
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic eab);
    acc(1'b0, a, 32'h0, rq, rab);
    chkBit("regAbort", eab, rab);
    chk("regRdata", e, rq);
  endtask
  // Hang guard; the whole run needs well under 10000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      conclude();
    end
  end
  // Accepted memory writes, judged at the falling edge where levels are settled
  always @(negedge clk) begin
    if (rst_n === 1'b1 && memWrValid === 1'b1 && memWrReady === 1'b1) begin
      chk("memWrAddr", base + 32'(4 * wrIdx), memWrAddr);
      chk("memWrData", 32'hA000_0000 + 32'(wrIdx), memWrData);
      wrIdx++;
    end
  end
  // Main sequence
  initial begin
    {rst_n, regReq, suppress_abort_return_ones, permitLoadValid, permitLoadValue, memWrError} = '0;
    regCmd = '0;
    memWrReady = 1'b1;
    base = 32'h0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rdx(OFS_CTRL_SET, CTRL_RESET, 1'b0);
    rdx(OFS_SID_BASE, 32'h0, 1'b0);
    rdx(OFS_SID_TALLY, 32'h0, 1'b0);
    rdx(12'h0A0, 32'h0, 1'b0);
    for (int v = 0; v < 2; v++) begin
      permitLoadValue = v[0];
      permitLoadValid = 1'b1;
      @(posedge clk);
      #1;
      permitLoadValid = 1'b0;
      rdx(OFS_CTRL_SET, {8'h00, v[0], 23'h0}, 1'b0);
    end
    wr(OFS_CTRL_SET, 32'h003E_0000);
    wr(OFS_CTRL_SET, 32'h0040_0000);
    rdx(OFS_CTRL_SET, 32'h00CE_0000, 1'b0);
    chkBit("linkActive", 1'b1, linkActive);
    chkBit("phy_extras_on", 1'b1, phy_extras_on);
    chkBit("buffered_write_allow", 1'b1, buffered_write_allow);
    wr(OFS_CTRL_CLR, 32'h0040_0000);
    rdx(OFS_CTRL_SET, 32'h008E_0000, 1'b0);
    wr(OFS_SID_BASE, ALL_ONES);
    rdx(OFS_SID_BASE, 32'hFFFF_F800, 1'b0);
    base = 32'h1234_5800;
    wr(OFS_SID_BASE, base);
    // PHY clock has not run yet, so the link ranges see it stopped
    repeat (40) @(posedge clk);
    for (int i = 0; i < 5; i++) rdx(phyAddr[i], 32'h0, i < 4);
    suppress_abort_return_ones = 1'b1;
    rdx(OFS_LINKA_HI, ALL_ONES, 1'b0);
    suppress_abort_return_ones = 1'b0;
    fork
      phy.burst(3, '0);
      begin
        // Scaled-down settling wait for the link clock before a link access
        repeat (20) @(posedge clk);
        rdx(OFS_LINKB_LO, 32'h0, 1'b0);
      end
    join
    // Stalled memory overflows the FIFO, then drains
    memWrReady = 1'b0;
    wrIdx = 0;
    phy.frame(18, 1'b0);
    acc(1'b0, OFS_SID_TALLY, 32'h0, rq, rab);
    chk("tally", 32'h8001_0000, rq & 32'hFFFF_0000);
    memWrReady = 1'b1;
    repeat (40) @(posedge clk);
    chk("drained", 32'd16, 32'(wrIdx));
    wrIdx = 0;
    phy.frame(3, 1'b0);
    rdx(OFS_SID_TALLY, 32'h0002_000C, 1'b0);
    wrIdx = 0;
    phy.frame(2, 1'b1);
    rdx(OFS_SID_TALLY, 32'h8003_0008, 1'b0);
    phy.burst(253, lcsr_link_type'(5'b10000));
    rdx(OFS_SID_TALLY, 32'h8000_0008, 1'b0);
    wr(OFS_CTRL_CLR, 32'h0002_0000);
    chkBit("linkActive", 1'b0, linkActive);
    phy.frame(1, 1'b0);
    rdx(OFS_SID_TALLY, 32'h8000_0008, 1'b0);
    wr(OFS_CTRL_SET, 32'h0001_0000);
    rdx(OFS_CTRL_SET, 32'h0081_0000, 1'b0);
    repeat (20) @(posedge clk);
    rdx(OFS_CTRL_SET, CTRL_RESET, 1'b0);
    rdx(OFS_SID_BASE, 32'h0, 1'b0);
    rdx(OFS_SID_TALLY, 32'h0, 1'b0);
    conclude();
  end
endmodule

// >>> verif/lcsr_phy_model.sv
// PHY-side model driving the link clock, event pins and quadlet data.
// Assumes the bench calls its tasks; the clock stands still between calls.
`timescale 1ns/10ps
module lcsr_phy_model import lcsr_pkg::*; (
  // Link pins toward the block
  output logic phyClkPin,
  output lcsr_link_type linkPins,
  output logic [31:0] phyDataPins
);
  // Idle at time zero
  initial begin
    phyClkPin = 1'b0;
    linkPins = '0;
    phyDataPins = 32'h5A5A_5A5A;
  end
  // One 160 ns cycle; pins settle 40 ns before the rise and hold 120 ns after it
  task automatic cyc(input lcsr_link_type p, input logic [31:0] d);
    linkPins = p;
    phyDataPins = d;
    #40;
    phyClkPin = 1'b1;
    #80;
    phyClkPin = 1'b0;
    #40;
  endtask
  // Pulse an event n times with idle cycles between; data never holds a stale value
  task automatic burst(input int n, input lcsr_link_type p);
    for (int i = 0; i < n; i++) begin
      cyc(p, ~phyDataPins);
      cyc('0, ~phyDataPins);
    end
    linkPins = '0;
  endtask
  // Bus reset, report begin, n quadlets (first may carry an error), report end
  task automatic frame(input int n, input logic err);
    lcsr_link_type p;
    p = '0;
    p.busReset = 1'b1;
    cyc(p, ~phyDataPins);
    p = '0;
    p.reportBegin = 1'b1;
    cyc(p, ~phyDataPins);
    for (int i = 0; i < n; i++) begin
      p = '0;
      p.quadValid = 1'b1;
      p.hwError = err && i == 0;
      cyc(p, 32'hA000_0000 + 32'(i));
    end
    p = '0;
    p.reportEnd = 1'b1;
    cyc(p, ~phyDataPins);
    linkPins = '0;
  endtask
endmodule
